// file: hw/codec_ctrl_device.sv
`timescale 1ns/1ps
module codec_ctrl_device
	import codec_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	codec_ctrl_if.device bus,
	input wire logic force_lock_ctrl,
	input wire logic [1:0] deemph_rate_select,
	input wire codec_ctrl_pkg::rate_type detected_rate,
	input wire logic receiver_emphasis,
	output logic receiver_reset,
	output logic adc_reset,
	output logic [codec_ctrl_pkg::DAC_PAIRS-1:0] dac_pair_reset,
	output logic low_power,
	output logic [1:0] converter_port_speed,
	output logic [1:0] audio_port_speed,
	output logic adc_on_converter_data_out,
	output logic adc_clock_from_audio_port,
	output logic receiver_on_interface_data_out,
	output codec_ctrl_pkg::rate_type dac_filter_rate,
	output codec_ctrl_pkg::rate_type receiver_filter_rate,
	output logic [1:0] interface_format,
	output logic [1:0] adc_single_line_mode,
	output logic [1:0] dac_single_line_mode,
	output logic interface_rj_width,
	output logic converter_rj_width
);
	import codec_ctrl_pkg::*;

	logic pointer_autoinc_reg;
	logic [6:0] pointer_reg;
	logic [7:0] power_control_reg;
	logic [7:0] functional_mode_reg;
	logic [7:0] interface_formats_reg;
	logic [7:0] rdata_reg;
	logic [7:0] read_value;
	logic access;
	route_type route;

	function automatic logic [7:0] read_mux(input logic [6:0] ofs, input logic [7:0] pc,
		input logic [7:0] fm, input logic [7:0] ifm);
		case (ofs)
			IDENTITY_REVISION_OFS: read_mux = {PART_CODE, SILICON_REVISION};
			POWER_CONTROL_OFS: read_mux = pc;
			FUNCTIONAL_MODE_OFS: read_mux = fm;
			INTERFACE_FORMATS_OFS: read_mux = ifm;
			default: read_mux = 8'h00;
		endcase
	endfunction

	function automatic logic [1:0] field2(input logic [7:0] value, input int lsb);
		field2 = value[lsb +: 2];
	endfunction

	assign access = bus.reg_wr || bus.reg_rd;
	assign read_value = read_mux(pointer_reg, power_control_reg, functional_mode_reg,
		interface_formats_reg);
	assign bus.ready = 1'b1;
	assign bus.rdata = rdata_reg;

	// pointer load and advance
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pointer_autoinc_reg <= POINTER_AUTOINC_RESET;
			pointer_reg <= POINTER_RESET;
		end else if (clk_en) begin
			if (bus.ptr_wr) begin
				pointer_autoinc_reg <= bus.wdata[POINTER_AUTOINC_BIT];
				pointer_reg <= bus.wdata[6:0];
			end else if (access && pointer_autoinc_reg) begin
				pointer_reg <= pointer_reg + 7'h01;
			end
		end
	end

	// register writes; identity register ignores writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			power_control_reg <= POWER_CONTROL_RESET;
			functional_mode_reg <= FUNCTIONAL_MODE_RESET;
			interface_formats_reg <= INTERFACE_FORMATS_RESET;
		end else if (clk_en && bus.reg_wr && !bus.ptr_wr) begin
			// a pointer load in the same cycle wins over the write
			case (pointer_reg)
				POWER_CONTROL_OFS: begin
					power_control_reg <= bus.wdata;
				end
				FUNCTIONAL_MODE_OFS: begin
					functional_mode_reg <= bus.wdata;
				end
				INTERFACE_FORMATS_OFS: begin
					interface_formats_reg <= bus.wdata;
				end
				default: ;
			endcase
		end
	end

	// read data captured at the access
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rdata_reg <= 8'h00;
		else if (clk_en && bus.reg_rd && !bus.ptr_wr)
			rdata_reg <= read_value;
	end

	// reserved code 10 is treated as held
	always_comb begin
		receiver_reset = 1'b1;
		case (power_control_reg[RCV_PDN_MSB:RCV_PDN_LSB])
			2'b00: receiver_reset = 1'b0;
			2'b01: receiver_reset = 1'b1;
			2'b11: receiver_reset = 1'b1;
			default: receiver_reset = 1'b1;
		endcase
	end
	assign adc_reset = power_control_reg[ADC_PDN_BIT];
	assign low_power = power_control_reg[GLOBAL_PDN_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < DAC_PAIRS; gi++) begin : g_dac
			assign dac_pair_reset[gi] = power_control_reg[DAC_PDN_LSB + gi];
		end
	endgenerate

	assign converter_port_speed = field2(functional_mode_reg, CONV_SPEED_LSB);
	assign audio_port_speed = field2(functional_mode_reg, AUDIO_SPEED_LSB);
	assign route = route_type'(field2(functional_mode_reg, ADC_ROUTE_LSB));

	always_comb begin
		adc_on_converter_data_out = 1'b1;
		adc_clock_from_audio_port = 1'b0;
		receiver_on_interface_data_out = 1'b1;
		case (route)
			ROUTE_CONV_CONV: begin
				adc_on_converter_data_out = 1'b1;
				adc_clock_from_audio_port = 1'b0;
				receiver_on_interface_data_out = 1'b1;
			end
			ROUTE_CONV_AUDIO: begin
				adc_on_converter_data_out = 1'b1;
				adc_clock_from_audio_port = 1'b1;
				receiver_on_interface_data_out = 1'b1;
			end
			ROUTE_AUDIO: begin
				adc_on_converter_data_out = 1'b0;
				adc_clock_from_audio_port = 1'b1;
				receiver_on_interface_data_out = 1'b0;
			end
			// reserved code keeps the power-on routing
			default: begin
				adc_on_converter_data_out = 1'b1;
				adc_clock_from_audio_port = 1'b0;
				receiver_on_interface_data_out = 1'b1;
			end
		endcase
	end

	deemph_select u_dac_deemph (
		.enable(functional_mode_reg[DAC_DEEMPH_BIT]),
		.force_lock_ctrl(force_lock_ctrl),
		.deemph_rate_select(deemph_rate_select),
		.detected_rate(detected_rate),
		.emphasis_flag(1'b1),
		.filter_rate(dac_filter_rate)
	);

	deemph_select u_rcv_deemph (
		.enable(functional_mode_reg[RCV_DEEMPH_BIT]),
		.force_lock_ctrl(force_lock_ctrl),
		.deemph_rate_select(deemph_rate_select),
		.detected_rate(detected_rate),
		.emphasis_flag(receiver_emphasis),
		.filter_rate(receiver_filter_rate)
	);

	assign interface_format = field2(interface_formats_reg, FORMAT_LSB);
	assign adc_single_line_mode = field2(interface_formats_reg, ADC_LINE_LSB);
	assign dac_single_line_mode = field2(interface_formats_reg, DAC_LINE_LSB);
	assign interface_rj_width = interface_formats_reg[AUDIO_RJ_BIT];
	assign converter_rj_width = interface_formats_reg[CONV_RJ_BIT];
endmodule

// file: hw/codec_ctrl_pkg.sv
package codec_ctrl_pkg;
	localparam logic [6:0] IDENTITY_REVISION_OFS = 7'h01;
	localparam logic [6:0] POWER_CONTROL_OFS = 7'h02;
	localparam logic [6:0] FUNCTIONAL_MODE_OFS = 7'h03;
	localparam logic [6:0] INTERFACE_FORMATS_OFS = 7'h04;
	localparam logic [6:0] POINTER_RESET = 7'h01;
	localparam logic POINTER_AUTOINC_RESET = 1'b1;
	localparam int POINTER_AUTOINC_BIT = 7;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h81;
	localparam logic [7:0] FUNCTIONAL_MODE_RESET = 8'h00;
	localparam logic [7:0] INTERFACE_FORMATS_RESET = 8'h40;
	// part and revision codes are arbitrary
	localparam logic [3:0] PART_CODE = 4'h5;
	localparam logic [3:0] SILICON_REVISION = 4'h2;
	localparam int RCV_PDN_MSB = 7;
	localparam int RCV_PDN_LSB = 6;
	localparam int ADC_PDN_BIT = 5;
	localparam int DAC_PDN_LSB = 1;
	localparam int GLOBAL_PDN_BIT = 0;
	localparam int CONV_SPEED_LSB = 6;
	localparam int AUDIO_SPEED_LSB = 4;
	localparam int ADC_ROUTE_LSB = 2;
	localparam int DAC_DEEMPH_BIT = 1;
	localparam int RCV_DEEMPH_BIT = 0;
	localparam int FORMAT_LSB = 6;
	localparam int ADC_LINE_LSB = 4;
	localparam int DAC_LINE_LSB = 2;
	localparam int AUDIO_RJ_BIT = 1;
	localparam int CONV_RJ_BIT = 0;
	localparam int DAC_PAIRS = 4;
	typedef enum logic [1:0] {
		RATE_NONE = 2'b00,
		RATE_32K = 2'b01,
		RATE_44K1 = 2'b10,
		RATE_48K = 2'b11
	} rate_type;
	typedef enum logic [1:0] {
		ROUTE_CONV_CONV = 2'b00,
		ROUTE_CONV_AUDIO = 2'b01,
		ROUTE_AUDIO = 2'b10,
		ROUTE_RESERVED = 2'b11
	} route_type;
endpackage

// file: hw/codec_ctrl_if.sv
`timescale 1ns/1ps
interface codec_ctrl_if;
	logic ptr_wr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ready;
	modport device (input ptr_wr, input reg_wr, input reg_rd, input wdata,
		output rdata, output ready);
	modport host (output ptr_wr, output reg_wr, output reg_rd, output wdata,
		input rdata, input ready);
endinterface

// file: hw/deemph_select.sv
`timescale 1ns/1ps
module deemph_select
	import codec_ctrl_pkg::*;
(
	input wire logic enable,
	input wire logic force_lock_ctrl,
	input wire logic [1:0] deemph_rate_select,
	input wire codec_ctrl_pkg::rate_type detected_rate,
	input wire logic emphasis_flag,
	output codec_ctrl_pkg::rate_type filter_rate
);
	import codec_ctrl_pkg::*;

	always_comb begin
		filter_rate = RATE_NONE;
		if (enable && emphasis_flag) begin
			if (force_lock_ctrl)
				filter_rate = rate_type'(deemph_rate_select);
			else
				filter_rate = detected_rate;
		end
	end
endmodule

// file: hw/codec_ctrl_host.sv
`timescale 1ns/1ps
module codec_ctrl_host
	import codec_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	codec_ctrl_if.host bus,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [6:0] cmd_addr,
	input wire logic cmd_autoinc,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data
);
	import codec_ctrl_pkg::*;

	typedef enum logic [1:0] {IDLE, POINT, ACCESS, CAPTURE} state_type;
	state_type state_reg;
	logic write_reg;
	logic [7:0] wdata_reg;
	logic [7:0] ptr_reg;

	assign cmd_ready = (state_reg == IDLE);
	assign bus.ptr_wr = (state_reg == POINT);
	assign bus.reg_wr = (state_reg == ACCESS) && write_reg;
	assign bus.reg_rd = (state_reg == ACCESS) && !write_reg;
	assign bus.wdata = (state_reg == POINT) ? ptr_reg : wdata_reg;

	// pointer always loaded before each access
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= IDLE;
			write_reg <= 1'b0;
			wdata_reg <= 8'h00;
			ptr_reg <= 8'h00;
		end else if (clk_en) begin
			case (state_reg)
				IDLE: if (cmd_valid) begin
					write_reg <= cmd_write;
					wdata_reg <= cmd_wdata;
					ptr_reg <= {cmd_autoinc, cmd_addr};
					state_reg <= POINT;
				end
				POINT: state_reg <= ACCESS;
				ACCESS: state_reg <= write_reg ? IDLE : CAPTURE;
				CAPTURE: state_reg <= IDLE;
				default: state_reg <= IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else if (clk_en) begin
			rsp_valid <= (state_reg == CAPTURE);
			if (state_reg == CAPTURE)
				rsp_data <= bus.rdata;
		end
	end
endmodule

// file: test/codec_ctrl_checker.sv
`timescale 1ns/1ps
module codec_ctrl_checker
	import codec_ctrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ptr_wr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ready
);
	logic [6:0] ptr_reg;
	logic inc_reg;
	logic [7:0] sh_reg [2:4];
	logic [7:0] exp_next;
	wire acc = reg_wr || reg_rd;
	wire rd_only = reg_rd && !ptr_wr;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ptr_reg <= POINTER_RESET;
			inc_reg <= POINTER_AUTOINC_RESET;
		end else if (ptr_wr) begin
			ptr_reg <= wdata[6:0];
			inc_reg <= wdata[7];
		end else if (acc && inc_reg) begin
			ptr_reg <= ptr_reg + 7'h01;
		end
	end
	// shadow of the writable registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sh_reg[2] <= POWER_CONTROL_RESET;
			sh_reg[3] <= FUNCTIONAL_MODE_RESET;
			sh_reg[4] <= INTERFACE_FORMATS_RESET;
		end else if (reg_wr && !ptr_wr && ptr_reg >= 7'h02 && ptr_reg <= 7'h04) begin
			sh_reg[ptr_reg] <= wdata;
		end
	end
	always_comb begin
		exp_next = 8'h00;
		if (ptr_reg == IDENTITY_REVISION_OFS) begin
			exp_next = {PART_CODE, SILICON_REVISION};
		end else if (ptr_reg >= 7'h02 && ptr_reg <= 7'h04) begin
			exp_next = sh_reg[ptr_reg];
		end
	end
	sequence s_load;
		ptr_wr && !acc;
	endsequence
	sequence s_access;
		acc && !(reg_wr && reg_rd);
	endsequence
	AST_LOAD_THEN_ACCESS: assert property (s_load |=> s_access)
		else $error("pointer load not followed by one access");
	AST_ACCESS_LOADED: assert property (acc |-> $past(ptr_wr))
		else $error("access without pointer load");
	AST_READ_VALUE: assert property (rd_only |=> rdata == $past(exp_next))
		else $error("read data differs from register contents");
	AST_ID_CODE: assert property (rd_only && ptr_reg == 7'h01 |=> rdata[7:4] == PART_CODE)
		else $error("identity read wrong part code");
	AST_UNMAPPED_ZERO: assert property (rd_only && (ptr_reg == 7'h00 || ptr_reg > 7'h04)
		|=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(rdata))
		else $error("read data changed without read");
	AST_READY_HIGH: assert property (ready)
		else $error("ready low");
	AST_RD_PULSE: assert property (reg_rd |=> !acc)
		else $error("access right after read");
endmodule

// file: test/codec_control_register_bank_test.sv
`timescale 1ns/1ps
module codec_control_register_bank_test;
	import codec_ctrl_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_autoinc = 1'b1, cmd_ready, rsp_valid;
	logic [6:0] cmd_addr = 7'h00;
	logic [7:0] cmd_wdata = 8'h00, rsp_data, q;
	logic force_lock_ctrl = 1'b0, receiver_emphasis = 1'b0;
	logic [1:0] deemph_rate_select = 2'b00;
	rate_type detected_rate = RATE_NONE;
	rate_type dac_filter_rate, receiver_filter_rate;
	logic receiver_reset, adc_reset, low_power, adc_on_cdo, adc_clk_ap, rcv_on_ido, irj, crj;
	logic [3:0] dac_pair_reset;
	logic [1:0] cps, aps, ifmt, asl, dsl;
	logic [7:0] pv [6] = '{8'h01, 8'h41, 8'hc1, 8'h03, 8'h3f, 8'h21};
	logic [2:0] rt [3] = '{3'b101, 3'b111, 3'b010};
	int n_errors = 0;
	int num_checks = 0;
	codec_ctrl_if bus ();
	codec_ctrl_host u_codec_ctrl_host (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1),
		.bus(bus.host), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_autoinc(cmd_autoinc), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	codec_ctrl_device u_codec_ctrl_device (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1),
		.bus(bus.device), .force_lock_ctrl(force_lock_ctrl),
		.deemph_rate_select(deemph_rate_select), .detected_rate(detected_rate),
		.receiver_emphasis(receiver_emphasis), .receiver_reset(receiver_reset),
		.adc_reset(adc_reset), .dac_pair_reset(dac_pair_reset), .low_power(low_power),
		.converter_port_speed(cps), .audio_port_speed(aps),
		.adc_on_converter_data_out(adc_on_cdo), .adc_clock_from_audio_port(adc_clk_ap),
		.receiver_on_interface_data_out(rcv_on_ido), .dac_filter_rate(dac_filter_rate),
		.receiver_filter_rate(receiver_filter_rate), .interface_format(ifmt),
		.adc_single_line_mode(asl), .dac_single_line_mode(dsl),
		.interface_rj_width(irj), .converter_rj_width(crj));
	codec_ctrl_checker u_codec_ctrl_checker (.clk_sys(clk_sys), .resetn(resetn),
		.ptr_wr(bus.ptr_wr), .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd), .wdata(bus.wdata),
		.rdata(bus.rdata), .ready(bus.ready));
	always #20 clk_sys = ~clk_sys;
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR register %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_out(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR output %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		while (((wr ? cmd_ready : rsp_valid) !== 1'b1) && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		q = rsp_data;
		if (n >= 50) begin
			n_errors++;
			$display("ERROR handshake timeout");
			stop_test();
		end
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
		xfer(1'b0, a, 8'h00);
		chk_reg(nm, e, q);
	endtask
	function automatic logic [7:0] pwr_o();
		return {1'b0, receiver_reset, adc_reset, dac_pair_reset, low_power};
	endfunction
	initial begin
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		rd(IDENTITY_REVISION_OFS, {PART_CODE, SILICON_REVISION}, "ident");
		rd(POWER_CONTROL_OFS, 8'h81, "power");
		rd(FUNCTIONAL_MODE_OFS, 8'h00, "mode");
		rd(INTERFACE_FORMATS_OFS, 8'h40, "format");
		rd(7'h05, 8'h00, "unmapped");
		chk_out("powerdown", 8'h41, pwr_o());
		xfer(1'b1, IDENTITY_REVISION_OFS, 8'hff);
		rd(IDENTITY_REVISION_OFS, {PART_CODE, SILICON_REVISION}, "ident ro");
		$display("defaults done");
		foreach (pv[i]) begin
			xfer(1'b1, POWER_CONTROL_OFS, pv[i]);
			rd(POWER_CONTROL_OFS, pv[i], "power");
			chk_out("powerdown", {1'b0, pv[i][7] | pv[i][6], pv[i][5:0]}, pwr_o());
		end
		$display("power done");
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, FUNCTIONAL_MODE_OFS, {2'(i), 2'(2 - i), 2'(i), 2'b00});
			chk_out("speed", {4'h0, 2'(i), 2'(2 - i)}, {4'h0, cps, aps});
			chk_out("route", {5'h0, rt[i]}, {5'h0, adc_on_cdo, adc_clk_ap, rcv_on_ido});
		end
		xfer(1'b1, FUNCTIONAL_MODE_OFS, 8'h03);
		force_lock_ctrl = 1'b1;
		receiver_emphasis = 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(negedge clk_sys);
			deemph_rate_select = 2'(k);
			#1;
			chk_out("dac rate", 8'(k), {6'h0, dac_filter_rate});
			chk_out("rcv rate", 8'(k), {6'h0, receiver_filter_rate});
		end
		@(negedge clk_sys);
		force_lock_ctrl = 1'b0;
		detected_rate = RATE_44K1;
		#1;
		chk_out("dac rate", 8'h02, {6'h0, dac_filter_rate});
		chk_out("rcv rate", 8'h02, {6'h0, receiver_filter_rate});
		@(negedge clk_sys);
		receiver_emphasis = 1'b0;
		#1;
		chk_out("rcv rate", 8'h00, {6'h0, receiver_filter_rate});
		@(negedge clk_sys);
		xfer(1'b1, FUNCTIONAL_MODE_OFS, 8'h00);
		chk_out("dac rate", 8'h00, {6'h0, dac_filter_rate});
		$display("mode done");
		xfer(1'b1, INTERFACE_FORMATS_OFS, 8'ha7);
		rd(INTERFACE_FORMATS_OFS, 8'ha7, "format");
		chk_out("format", 8'ha7, {ifmt, asl, dsl, irj, crj});
		@(negedge clk_sys);
		resetn = 1'b0;
		@(negedge clk_sys);
		resetn = 1'b1;
		rd(POWER_CONTROL_OFS, 8'h81, "power");
		cmd_autoinc = 1'b0;
		rd(INTERFACE_FORMATS_OFS, 8'h40, "format");
		cmd_autoinc = 1'b1;
		$display("formats and reset done");
		stop_test();
	end
endmodule
